//--- ppm_pkg.sv
package ppm_pkg;
   localparam logic [7:0] OFF_CFG = 8'h00;
   localparam logic [7:0] OFF_ADDR = 8'h04;
   localparam logic [7:0] OFF_DATA = 8'h08;
   localparam logic [7:0] OFF_STAT = 8'h0C;
   localparam logic [7:0] OFF_SLV_IN = 8'h10;
   localparam logic [7:0] OFF_SLV_OUT = 8'h14;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   localparam logic [10:0] ADDR_RESET = 11'h000;
   localparam logic [3:0] SETUP_CYC_00 = 4'h1;
   localparam logic [3:0] SETUP_CYC_01 = 4'h2;
   localparam logic [3:0] SETUP_CYC_10 = 4'h3;
   localparam logic [3:0] SETUP_CYC_11 = 4'h4;

   typedef enum logic [1:0] {
      OP_LEGACY = 2'h0,
      OP_ENH = 2'h1,
      OP_MASTER2 = 2'h2,
      OP_MASTER1 = 2'h3
   } ppm_opmode_e;

   typedef enum logic [1:0] {
      STEP_HOLD = 2'h0,
      STEP_INC = 2'h1,
      STEP_DEC = 2'h2,
      STEP_BUF = 2'h3
   } ppm_step_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_SETUP = 2'h1,
      ST_STROBE = 2'h3,
      ST_HOLD = 2'h2
   } ppm_state_e;

   typedef struct packed {
      logic [2:0] rsvd;
      ppm_step_e address_step_select;
      logic wide_transfer_select;
      ppm_opmode_e port_operating_select;
      logic [1:0] data_setup_wait;
      logic [3:0] strobe_wait_count;
      logic [1:0] data_hold_wait;
   } ppm_cfg_s;

   typedef struct packed {
      logic port_chip_select;
      logic port_direction_line;
      logic port_enable_strobe;
      logic port_read_strobe;
      logic port_write_strobe;
      logic port_byte_enable;
      logic [10:0] port_address_lines;
      logic [7:0] port_data_out;
      logic port_data_oe;
   } ppm_pins_s;

   typedef struct packed {
      logic host_chip_select;
      logic host_read_strobe;
      logic host_write_strobe;
      logic [1:0] host_address;
      logic [7:0] port_data_in;
   } ppm_pin_in_s;

   function automatic logic [3:0] setup_cycles(input logic [1:0] sel);
      case (sel)
         2'h0: setup_cycles = SETUP_CYC_00;
         2'h1: setup_cycles = SETUP_CYC_01;
         2'h2: setup_cycles = SETUP_CYC_10;
         default: setup_cycles = SETUP_CYC_11;
      endcase
   endfunction : setup_cycles
endpackage : ppm_pkg

//--- ppm_addr_step.sv
`timescale 1ns/1ps
`default_nettype none
module ppm_addr_step (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire logic [10:0] load_val_i,
   input wire logic step_i,
   input wire ppm_pkg::ppm_step_e sel_i,
   output logic [10:0] addr_o
);
   import ppm_pkg::*;
   logic [10:0] addr_reg;
   logic [10:0] addr_next;

   always_comb begin
      addr_next = addr_reg;
      if (load_i) begin
         addr_next = load_val_i;
      end else if (step_i) begin
         unique case (sel_i)
            STEP_INC: addr_next = addr_reg + 11'h001;
            STEP_DEC: addr_next = addr_reg - 11'h001;
            STEP_HOLD: addr_next = addr_reg;
            STEP_BUF: addr_next = addr_reg;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr_reg <= ADDR_RESET;
      end else begin
         addr_reg <= addr_next;
      end
   end

   assign addr_o = addr_reg;
endmodule : ppm_addr_step
`default_nettype wire

//--- ppm_top.sv
`timescale 1ns/1ps
`default_nettype none
module ppm_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire ppm_pkg::ppm_pin_in_s pin_i,
   output ppm_pkg::ppm_pins_s pins_o
);
   import ppm_pkg::*;

   ppm_cfg_s cfg_reg;
   ppm_cfg_s xcfg_reg;
   ppm_state_e st_reg;
   logic [3:0] cnt_reg;
   logic byte_hi_reg;
   logic is_read_reg;
   logic busy_reg;
   logic [15:0] wdata_reg;
   logic [15:0] rdata_reg;
   logic ack_reg;
   logic [31:0] dat_reg;
   logic [31:0] dat_next;
   ppm_pins_s pins_reg;
   ppm_pins_s pins_next;
   logic [3:0][7:0] in_buf_reg;
   logic [3:0][7:0] out_buf_reg;
   logic [1:0] rd_ptr_reg;
   logic [1:0] wr_ptr_reg;
   logic host_rd_prev_reg;
   logic host_wr_prev_reg;
   logic [10:0] addr_q;

   logic wb_req;
   logic is_master;
   logic start;
   logic byte_end;
   logic more;
   logic xfer_done;
   logic host_rd_end;
   logic host_wr_end;
   logic buf_step;
   logic [1:0] slv_rd_idx;
   logic [1:0] slv_wr_idx;

   assign wb_req = wb_cyc_i && wb_stb_i;
   assign is_master = cfg_reg.port_operating_select inside {OP_MASTER1, OP_MASTER2};
   // a data access in a master mode stalls the bus until the port transfer ends
   assign start = wb_req && !ack_reg && !busy_reg && is_master
                  && wb_adr_i == OFF_DATA && st_reg == ST_IDLE;
   assign byte_end = (st_reg == ST_STROBE && cnt_reg == 4'h0 && xcfg_reg.data_hold_wait == 2'h0)
                     || (st_reg == ST_HOLD && cnt_reg == 4'h0);
   assign more = xcfg_reg.wide_transfer_select && !byte_hi_reg;
   assign xfer_done = byte_end && !more;

   ppm_addr_step u_addr (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(wb_req && wb_we_i && !ack_reg && wb_adr_i == OFF_ADDR && !busy_reg),
      .load_val_i(wb_dat_i[10:0]),
      .step_i(byte_end),
      .sel_i(xcfg_reg.address_step_select),
      .addr_o(addr_q)
   );

   // configuration register, byte lanes honoured
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_reg <= CFG_RESET;
      end else if (wb_req && wb_we_i && !ack_reg && wb_adr_i == OFF_CFG) begin
         if (wb_sel_i[0]) begin
            cfg_reg[7:0] <= wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            cfg_reg[15:8] <= {3'h0, wb_dat_i[12:8]};
         end
      end
   end

   // transfer sequencer; wait fields are latched, so a config write mid-transfer keeps the timing; one to a slave mode drops chip select and strobes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= ST_IDLE;
         cnt_reg <= 4'h0;
         xcfg_reg <= CFG_RESET;
         byte_hi_reg <= 1'b0;
         is_read_reg <= 1'b0;
         wdata_reg <= 16'h0000;
         busy_reg <= 1'b0;
      end else begin
         unique case (st_reg)
            ST_IDLE: begin
               if (start) begin
                  st_reg <= ST_SETUP;
                  xcfg_reg <= cfg_reg;
                  cnt_reg <= setup_cycles(cfg_reg.data_setup_wait) - 4'h1;
                  byte_hi_reg <= 1'b0;
                  is_read_reg <= !wb_we_i;
                  wdata_reg <= wb_dat_i[15:0];
                  busy_reg <= 1'b1;
               end
            end
            ST_SETUP: begin
               if (cnt_reg == 4'h0) begin
                  st_reg <= ST_STROBE;
                  cnt_reg <= xcfg_reg.strobe_wait_count;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            ST_STROBE: begin
               if (cnt_reg != 4'h0) begin
                  cnt_reg <= cnt_reg - 4'h1;
               end else if (xcfg_reg.data_hold_wait != 2'h0) begin
                  st_reg <= ST_HOLD;
                  cnt_reg <= {2'h0, xcfg_reg.data_hold_wait} - 4'h1;
               end
            end
            ST_HOLD: begin
               if (cnt_reg != 4'h0) begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
         endcase
         if (byte_end) begin
            if (more) begin
               st_reg <= ST_SETUP;
               byte_hi_reg <= 1'b1;
               cnt_reg <= setup_cycles(xcfg_reg.data_setup_wait) - 4'h1;
            end else begin
               st_reg <= ST_IDLE;
               busy_reg <= 1'b0;
            end
         end
      end
   end

   // read byte captured at the last strobe cycle, low byte first
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_reg <= 16'h0000;
      end else if (st_reg == ST_STROBE && cnt_reg == 4'h0 && is_read_reg) begin
         if (byte_hi_reg) begin
            rdata_reg[15:8] <= pin_i.port_data_in;
         end else begin
            rdata_reg[7:0] <= pin_i.port_data_in;
         end
      end
   end

   // slave side: host strobes are active high, actions on their falling edge
   assign host_rd_end = host_rd_prev_reg && !pin_i.host_read_strobe && pin_i.host_chip_select;
   assign host_wr_end = host_wr_prev_reg && !pin_i.host_write_strobe && pin_i.host_chip_select;
   assign buf_step = cfg_reg.port_operating_select == OP_LEGACY
                     && cfg_reg.address_step_select == STEP_BUF;
   assign slv_rd_idx = (cfg_reg.port_operating_select == OP_ENH) ? pin_i.host_address
                                                                 : rd_ptr_reg;
   assign slv_wr_idx = (cfg_reg.port_operating_select == OP_ENH) ? pin_i.host_address
                                                                 : wr_ptr_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         host_rd_prev_reg <= 1'b0;
         host_wr_prev_reg <= 1'b0;
         rd_ptr_reg <= 2'h0;
         wr_ptr_reg <= 2'h0;
      end else begin
         host_rd_prev_reg <= pin_i.host_read_strobe;
         host_wr_prev_reg <= pin_i.host_write_strobe;
         if (!buf_step) begin
            rd_ptr_reg <= 2'h0;
            wr_ptr_reg <= 2'h0;
         end else begin
            if (host_rd_end) begin
               rd_ptr_reg <= rd_ptr_reg + 2'h1;
            end
            if (host_wr_end) begin
               wr_ptr_reg <= wr_ptr_reg + 2'h1;
            end
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_lane
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               in_buf_reg[g] <= 8'h00;
               out_buf_reg[g] <= 8'h00;
            end else begin
               if (host_wr_end && !is_master && slv_wr_idx == g) begin
                  in_buf_reg[g] <= pin_i.port_data_in;
               end
               if (wb_req && wb_we_i && !ack_reg && wb_adr_i == OFF_SLV_OUT && wb_sel_i[g]) begin
                  out_buf_reg[g] <= wb_dat_i[8*g +: 8];
               end
            end
         end
      end
   endgenerate

   // pin decode, registered one cycle later so every pin leaves a flip-flop
   always_comb begin
      pins_next = '0;
      pins_next.port_address_lines = addr_q;
      if (is_master && busy_reg) begin
         pins_next.port_chip_select = 1'b1;
         pins_next.port_byte_enable = xcfg_reg.wide_transfer_select && st_reg == ST_STROBE;
         pins_next.port_data_out = byte_hi_reg ? wdata_reg[15:8] : wdata_reg[7:0];
         pins_next.port_data_oe = !is_read_reg;
         if (xcfg_reg.port_operating_select == OP_MASTER1) begin
            pins_next.port_direction_line = is_read_reg;
            pins_next.port_enable_strobe = st_reg == ST_STROBE;
         end else begin
            pins_next.port_read_strobe = is_read_reg && st_reg == ST_STROBE;
            pins_next.port_write_strobe = !is_read_reg && st_reg == ST_STROBE;
         end
      end else if (!is_master) begin
         pins_next.port_data_out = out_buf_reg[slv_rd_idx];
         pins_next.port_data_oe = pin_i.host_chip_select && pin_i.host_read_strobe;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pins_reg <= '0;
      end else begin
         pins_reg <= pins_next;
      end
   end

   // wishbone answer: one cycle for registers, end of transfer for master data
   always_comb begin
      unique case (wb_adr_i)
         OFF_CFG: dat_next = {16'h0000, cfg_reg};
         OFF_ADDR: dat_next = {21'h000000, addr_q};
         OFF_DATA: dat_next = {16'h0000, rdata_reg};
         OFF_STAT: dat_next = {27'h0000000, rd_ptr_reg, wr_ptr_reg, busy_reg};
         OFF_SLV_IN: dat_next = in_buf_reg;
         OFF_SLV_OUT: dat_next = out_buf_reg;
         default: dat_next = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
      end else if (ack_reg) begin
         ack_reg <= 1'b0;
      end else if (wb_req && is_master && wb_adr_i == OFF_DATA) begin
         ack_reg <= xfer_done;
         if (xfer_done && is_read_reg) begin
            if (st_reg == ST_HOLD) begin
               dat_reg <= byte_hi_reg ? {16'h0000, rdata_reg} : {24'h000000, rdata_reg[7:0]};
            end else if (!byte_hi_reg) begin
               dat_reg <= {24'h000000, pin_i.port_data_in};
            end else begin
               dat_reg <= {16'h0000, pin_i.port_data_in, rdata_reg[7:0]};
            end
         end
      end else if (wb_req) begin
         ack_reg <= 1'b1;
         dat_reg <= dat_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
   assign pins_o = pins_reg;

   // checking helpers
   logic [4:0] strobe_len;
   logic [2:0] hold_len;
   logic [1:0] bytes_len;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strobe_len <= 5'h00;
         hold_len <= 3'h0;
         bytes_len <= 2'h0;
      end else begin
         strobe_len <= (st_reg == ST_STROBE) ? strobe_len + 5'h01 : 5'h00;
         hold_len <= (st_reg == ST_HOLD) ? hold_len + 3'h1 : 3'h0;
         if (start) begin
            bytes_len <= 2'h0;
         end else if (byte_end) begin
            bytes_len <= bytes_len + 2'h1;
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_setup_enter;
      st_reg == ST_SETUP && $past(st_reg) != ST_SETUP;
   endsequence

   a_step_hold_addr: assert property (byte_end && xcfg_reg.address_step_select == STEP_HOLD
      |=> $stable(addr_q)) else $error("address moved with step hold");
   a_step_inc_addr: assert property (byte_end && xcfg_reg.address_step_select == STEP_INC
      |=> addr_q == $past(addr_q) + 11'h001) else $error("address did not increment");
   a_step_dec_addr: assert property (byte_end && xcfg_reg.address_step_select == STEP_DEC
      |=> addr_q == $past(addr_q) - 11'h001) else $error("address did not decrement");
   a_buf_ptr_step: assert property (buf_step && host_wr_end
      |=> wr_ptr_reg == $past(wr_ptr_reg) + 2'h1) else $error("write pointer stuck");
   a_wide_two_bytes: assert property (xfer_done && xcfg_reg.wide_transfer_select
      |-> bytes_len == 2'h1) else $error("wide access not two bytes");
   a_narrow_one_byte: assert property (xfer_done && !xcfg_reg.wide_transfer_select
      |-> bytes_len == 2'h0) else $error("narrow access not one byte");
   a_master1_enable: assert property (st_reg == ST_STROBE
      && xcfg_reg.port_operating_select == OP_MASTER1
      |=> pins_o.port_enable_strobe && pins_o.port_chip_select) else $error("enable strobe missing");
   a_master2_strobes: assert property (st_reg == ST_STROBE && is_read_reg
      && xcfg_reg.port_operating_select == OP_MASTER2
      |=> pins_o.port_read_strobe && !pins_o.port_write_strobe) else $error("read strobe missing");
   a_slave_drive_bus: assert property (!is_master && pin_i.host_chip_select
      && pin_i.host_read_strobe |=> pins_o.port_data_oe) else $error("slave not driving data");
   a_setup_four: assert property (s_setup_enter and xcfg_reg.data_setup_wait == 2'h3
      |-> (st_reg == ST_SETUP) [*4] ##1 st_reg == ST_STROBE) else $error("setup not four cycles");
   a_setup_one: assert property (s_setup_enter and xcfg_reg.data_setup_wait == 2'h0
      |=> st_reg == ST_STROBE) else $error("setup not one cycle");
   a_strobe_span: assert property ($fell(st_reg == ST_STROBE)
      |-> strobe_len == {1'b0, xcfg_reg.strobe_wait_count} + 5'h01) else $error("strobe length");
   a_strobe_single: assert property ($rose(st_reg == ST_STROBE)
      && xcfg_reg.strobe_wait_count == 4'h0 |=> st_reg != ST_STROBE) else $error("strobe too long");
   a_hold_span: assert property ($fell(st_reg == ST_HOLD)
      |-> hold_len == {1'b0, xcfg_reg.data_hold_wait}) else $error("hold length wrong");
   a_reload_setup: assert property (start
      |=> cnt_reg == setup_cycles(xcfg_reg.data_setup_wait) - 4'h1) else $error("no reload");
endmodule : ppm_top
`default_nettype wire

//--- ppm_port_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppm_port_model (
   input wire logic clk_i,
   input wire ppm_pkg::ppm_pins_s pins_i,
   output logic [7:0] data_o
);
   import ppm_pkg::*;
   logic [7:0] mem [0:2047];
   logic [7:0] last_q = 8'h00;
   logic [7:0] data_q = 8'h00;
   logic [10:0] addr_q = 11'h000;
   logic stb_q = 1'b0;
   logic wdir_q = 1'b0;
   int n_stb = 0;
   int width = 0;
   int run = 0;
   wire logic stb = pins_i.port_enable_strobe | pins_i.port_read_strobe
      | pins_i.port_write_strobe;
   wire logic wdir = pins_i.port_write_strobe
      | (pins_i.port_enable_strobe & ~pins_i.port_direction_line);

   initial begin
      for (int i = 0; i < 2048; i++) begin
         mem[i] = 8'(i) ^ 8'h5A;
      end
   end

   // deselected bus shows the inverted last byte so a stale value never passes
   assign data_o = pins_i.port_chip_select ? mem[pins_i.port_address_lines] : ~last_q;

   always @(posedge clk_i) begin
      stb_q <= stb;
      if (pins_i.port_chip_select) last_q <= data_o;
      if (stb) begin
         run <= run + 1;
         wdir_q <= wdir;
         data_q <= pins_i.port_data_out;
         addr_q <= pins_i.port_address_lines;
      end
      // write byte lands when the strobe ends, as a real memory would latch it
      if (stb_q && !stb) begin
         n_stb <= n_stb + 1;
         width <= run;
         run <= 0;
         if (wdir_q) mem[addr_q] <= data_q;
      end
   end
endmodule : ppm_port_model
`default_nettype wire

//--- ppm_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ppm_top_tb_top;
   import ppm_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [31:0] wb_dat = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic h_cs = 1'b0, h_rd = 1'b0, h_wr = 1'b0, h_drv = 1'b0;
   logic [1:0] h_adr = 2'h0;
   logic [7:0] h_dat = 8'h00;
   logic [7:0] mdl_dat;
   ppm_pins_s pins;
   ppm_pin_in_s pin_in;
   int n_errors = 0, n_compared = 0, cycles = 0, lat = 0, base = 0;
   logic [31:0] rv;
   logic [8:0] seen;
   logic [1:0] su_t [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
   logic [3:0] su_c [4] = '{SETUP_CYC_00, SETUP_CYC_11, SETUP_CYC_01, SETUP_CYC_10};
   logic [3:0] sw_t [4] = '{4'h0, 4'hF, 4'h1, 4'h0};
   logic [1:0] ho_t [4] = '{2'h0, 2'h3, 2'h1, 2'h2};

   assign pin_in = '{h_cs, h_rd, h_wr, h_adr, h_drv ? h_dat : mdl_dat};

   ppm_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_i(pin_in), .pins_o(pins));
   ppm_port_model mdl (.clk_i(clk_i), .pins_i(pins), .data_o(mdl_dat));

   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         final_report();
      end
   end

   task automatic final_report;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report

   task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
         n_errors++;
      end
   endtask : chk_val

   // lat counts edges up to the one that samples ack
   task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat <= d;
      lat = 0;
      do begin
         @(posedge clk_i);
         lat++;
      end while (wb_ack_o !== 1'b1);
      rv = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      // second idle edge lets the model land a strobe-end write before any check
      repeat (2) @(posedge clk_i);
   endtask : wb_xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb_xfer(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      wb_xfer(1'b0, a, 32'h0);
   endtask : rd

   // strobe drops a cycle before chip select so the byte is taken while selected
   task automatic host_op(input logic w, input logic [1:0] a, input logic [7:0] d);
      h_cs <= 1'b1;
      h_rd <= ~w;
      h_wr <= w;
      h_adr <= a;
      h_dat <= d;
      repeat (3) @(posedge clk_i);
      seen = {pins.port_data_oe, pins.port_data_out};
      h_rd <= 1'b0;
      h_wr <= 1'b0;
      @(posedge clk_i);
      h_cs <= 1'b0;
      h_dat <= ~d;
      @(posedge clk_i);
   endtask : host_op

   function automatic logic [31:0] mk_cfg(input logic [1:0] st, input logic w,
      input logic [1:0] m, input logic [1:0] su, input logic [3:0] sw, input logic [1:0] ho);
      return {19'h0, st, w, m, su, sw, ho};
   endfunction : mk_cfg

   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk_val("pins idle", 32'h0, 32'(pins));
      rd(OFF_CFG);
      chk_val("cfg reset", {16'h0, CFG_RESET}, rv);
      rd(OFF_ADDR);
      chk_val("addr reset", {21'h0, ADDR_RESET}, rv);
      wr(OFF_CFG, 32'hFFFF_FFFF);
      rd(OFF_CFG);
      chk_val("cfg rw", 32'h0000_1FFF, rv);
      wr(8'h20, 32'h0);
      rd(8'h20);
      chk_val("unmapped", 32'h0, rv);
      rd(OFF_CFG);
      chk_val("cfg kept", 32'h0000_1FFF, rv);
      // master 2, narrow write, step up
      wr(OFF_CFG, mk_cfg(2'h1, 1'b0, 2'h2, 2'h0, 4'h0, 2'h0));
      wr(OFF_ADDR, 32'h0000_0010);
      base = mdl.n_stb;
      wr(OFF_DATA, 32'h0000_003C);
      chk_val("m2 byte", 32'h3C, {24'h0, mdl.mem[16]});
      chk_val("m2 strobes", 32'h1, 32'(mdl.n_stb - base));
      rd(OFF_ADDR);
      chk_val("addr up", 32'h11, rv);
      // master 1, wide write, step down
      wr(OFF_CFG, mk_cfg(2'h2, 1'b1, 2'h3, 2'h0, 4'h0, 2'h0));
      wr(OFF_ADDR, 32'h0000_0100);
      base = mdl.n_stb;
      wr(OFF_DATA, 32'h0000_A55A);
      chk_val("m1 low byte", 32'h5A, {24'h0, mdl.mem[256]});
      chk_val("m1 high byte", 32'hA5, {24'h0, mdl.mem[255]});
      chk_val("m1 strobes", 32'h2, 32'(mdl.n_stb - base));
      rd(OFF_ADDR);
      chk_val("addr down", 32'hFE, rv);
      // master 1 wide read with one hold cycle, step up, then narrow read with step held
      wr(OFF_CFG, mk_cfg(2'h1, 1'b1, 2'h3, 2'h0, 4'h0, 2'h1));
      wr(OFF_ADDR, 32'h0000_0200);
      rd(OFF_DATA);
      chk_val("wide read", 32'h5B5A, {16'h0, rv[15:0]});
      rd(OFF_ADDR);
      chk_val("addr up twice", 32'h202, rv);
      wr(OFF_CFG, mk_cfg(2'h0, 1'b0, 2'h3, 2'h0, 4'h0, 2'h0));
      wr(OFF_ADDR, 32'h0000_0201);
      base = mdl.n_stb;
      rd(OFF_DATA);
      chk_val("narrow read", 32'h5B, {24'h0, rv[7:0]});
      chk_val("read strobes", 32'h1, 32'(mdl.n_stb - base));
      // wait-state table, fields reloaded on every transfer
      wr(OFF_ADDR, 32'h0000_0300);
      for (int i = 0; i < 4; i++) begin
         wr(OFF_CFG, mk_cfg(2'h0, 1'b0, 2'h2, su_t[i], sw_t[i], ho_t[i]));
         wr(OFF_DATA, 32'(8'hC0 + i));
         chk_val("xfer cycles", 32'(2 + su_c[i] + sw_t[i] + ho_t[i]), 32'(lat - 1));
         chk_val("strobe width", 32'(sw_t[i] + 1), 32'(mdl.width));
      end
      rd(OFF_ADDR);
      chk_val("addr held", 32'h300, rv);
      // enhanced slave: host address picks the slot
      h_drv <= 1'b1;
      wr(OFF_CFG, mk_cfg(2'h0, 1'b0, 2'h1, 2'h0, 4'h0, 2'h0));
      host_op(1'b1, 2'h2, 8'h77);
      rd(OFF_SLV_IN);
      chk_val("enh host write", 32'h77, {24'h0, rv[23:16]});
      wr(OFF_SLV_OUT, 32'h4433_2211);
      host_op(1'b0, 2'h1, 8'h00);
      chk_val("enh host read", 32'h122, {23'h0, seen});
      // legacy slave with buffer pointers advancing, address ignored
      wr(OFF_CFG, mk_cfg(2'h3, 1'b0, 2'h0, 2'h0, 4'h0, 2'h0));
      host_op(1'b1, 2'h3, 8'hA1);
      host_op(1'b1, 2'h3, 8'hB2);
      rd(OFF_SLV_IN);
      chk_val("legacy writes", 32'hB2A1, {16'h0, rv[15:0]});
      rd(OFF_STAT);
      chk_val("write pointer", 32'h2, {30'h0, rv[2:1]});
      host_op(1'b0, 2'h3, 8'h00);
      chk_val("legacy read 0", 32'h111, {23'h0, seen});
      host_op(1'b0, 2'h3, 8'h00);
      chk_val("legacy read 1", 32'h122, {23'h0, seen});
      final_report();
   end
endmodule : ppm_top_tb_top
`default_nettype wire
